// [sfr_pkg.sv]
// Purpose: shared constants and types for the serial flash read sequencer
// Assumes: sclk and chip select arrive asynchronously to mclk
// Notes: opcode values not fixed elsewhere are local choices
package sfr_pkg;

  // ************************************************************
  // Opcodes
  // ************************************************************
  localparam logic [7:0] CMD_QIO_EB = 8'hEB;
  localparam logic [7:0] CMD_QIO_EC = 8'hEC;
  localparam logic [7:0] CMD_QIO_ED = 8'hED;
  localparam logic [7:0] CMD_QIO_EE = 8'hEE;
  localparam logic [7:0] CMD_SET_BURST = 8'hC0;
  localparam logic [7:0] CMD_BOOT_PROG = 8'h16;
  localparam logic [7:0] CMD_BOOT_ERASE = 8'h18;
  localparam logic [7:0] CMD_BOOT_READ = 8'h17;
  localparam logic [7:0] CMD_RESET = 8'h99;

  // ************************************************************
  // Boot register layout and cycle counts
  // ************************************************************
  localparam logic [31:0] BOOT_ERASED = 32'hFFFF_FFFF;
  localparam int BOOT_EN_N_BIT = 0;
  localparam int BOOT_DLY_LSB = 1;
  localparam int BOOT_ADDR_LSB = 4;
  localparam int WRAP_OFF_BIT = 4;
  localparam logic [5:0] DUMMY_C0 = 6'h04;
  localparam logic [5:0] DUMMY_C1 = 6'h06;
  localparam logic [5:0] DUMMY_C2 = 6'h08;
  localparam logic [5:0] DUMMY_C3 = 6'h0A;
  localparam logic [5:0] DLY_C0 = 6'h07;
  localparam logic [5:0] DLY_C1 = 6'h09;
  localparam logic [5:0] DLY_C2 = 6'h0B;
  localparam logic [5:0] DLY_C3 = 6'h0D;
  localparam logic [3:0] EXIT_CLKS_3B = 4'h8;
  localparam logic [3:0] EXIT_CLKS_4B = 4'hA;
  localparam logic [1:0] FETCH_AHEAD = 2'h2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    SFR_IDLE = 4'h0, SFR_CMD = 4'h1, SFR_ADDR = 4'h3, SFR_MODE = 4'h2,
    SFR_DUMMY = 4'h6, SFR_DATA = 4'h7, SFR_BOOT = 4'h5, SFR_WRAP = 4'h4,
    SFR_BPROG = 4'hC, SFR_BREAD = 4'hD, SFR_SKIP = 4'hF
  } sfr_state_e;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] sio;
  } sfr_pin_s;

  typedef struct packed {
    logic [3:0] sio_out;
    logic [3:0] sio_oe;
  } sfr_drv_s;

endpackage

// [sfr_sync.sv]
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: each bit is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module sfr_sync #(
  parameter int WIDTH = 6
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  initial begin
    if (WIDTH < 1) $error("sfr_sync: WIDTH must be positive");
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '1;
      sync_out <= '1;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// [sfr_fifo2.sv]
// Purpose: small valid/ready buffer for read data
// Assumes: DEPTH is two or more
// Notes: full drops in_ready, so the source stalls
`timescale 1ns/1ps
`default_nettype none
module sfr_fifo2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 2) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg, rp_reg;
  logic [AW:0] cnt_reg;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  initial begin
    if (DEPTH < 2 || WIDTH < 1) $error("sfr_fifo2: bad size");
  end

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rp_reg];

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = (p == AW'(DEPTH-1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge mclk) begin
    if (push) mem[wp_reg] <= in_data;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wp_reg <= inc(wp_reg);
      if (pop) rp_reg <= inc(rp_reg);
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// [sfr_seq.sv]
// Purpose: flash-side read sequencer: enhance mode, wrap, boot read-out
// Assumes: sclk much slower than mclk; sample rising, drive falling
// Notes: array data comes over mem_req/mem_rsp through a two-entry buffer
//
// Functional notes
// R1: Toggled mode nibbles keep continuous-read mode
// R2: Any equal nibble bit pair leaves continuous mode
// R3: Continuous mode only on quad opcodes EB..EE
// R4: In continuous mode frames start with address
// R5: Host exits with ones on one line
// R6: Host exits with ones on four lines
// R7: Reset returns to single-line, leaves continuous mode; here reset clears cont_reg and wrap_en_reg, qpi_mode is an input it never changes
// R8: Order: command, address, mode, dummy, data
// R9: Dummy count taken from two configuration bits
// R10: Wrap disabled after power-up and reset
// R11: Wrap code sets 8/16/32/64 or off
// R12: Wrapped address stays inside aligned block
// R13: Host sends burst command then one code
// R14: Command accepted as 8 or 2 clocks
// R15: Wrap kept; applies to EB/EC quad, EC single
// R16: Boot read starts after any reset
// R17: Boot enabled when register bit 0 clear
// R18: Boot waits delay, sends data, then commands
// R19: Host holds select for one byte
// R20: Boot delay field selects 7/9/11/13
// R21: Boot address bits 31..4, 16-byte aligned
// R22: Boot data on one or four lines
// R23: Boot register program, erase, read commands
`timescale 1ns/1ps
`default_nettype none
module sfr_seq #(
  parameter logic [31:0] BOOT_NV_INIT = 32'hFFFF_FFFF,
  parameter int BUF_DEPTH = 2
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire sfr_pkg::sfr_pin_s pin_i,
  output sfr_pkg::sfr_drv_s drv_o,
  input wire logic qpi_mode,
  input wire logic addr4_mode,
  input wire logic quad_enable_bit,
  input wire logic dummy_cfg_lo,
  input wire logic dummy_cfg_hi,
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic [31:0] mem_req_addr,
  input wire logic mem_rsp_valid,
  output logic mem_rsp_ready,
  input wire logic [7:0] mem_rsp_data,
  output logic cont_mode_o,
  output logic wrap_en_o,
  output logic [31:0] boot_readout_config
);
  import sfr_pkg::*;

  // ************************************************************
  // Reset release and pin sampling
  // ************************************************************
  logic rs1_reg, rst_n;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rs1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_reg <= 1'b1;
      rst_n <= rs1_reg;
    end
  end

  sfr_pin_s s_pin;
  sfr_sync #(.WIDTH(6)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(pin_i),
    .sync_out(s_pin)
  );

  logic sclk_d_reg, cs_d_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_reg <= 1'b1;
      cs_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= s_pin.sclk;
      cs_d_reg <= s_pin.cs_n;
    end
  end
  wire rise = s_pin.sclk & ~sclk_d_reg;
  wire fall = ~s_pin.sclk & sclk_d_reg;
  wire cs_fall = ~s_pin.cs_n & cs_d_reg;
  wire cs_rise = s_pin.cs_n & ~cs_d_reg;

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [31:0] shin(input logic [31:0] s,
                                       input logic [3:0] d,
                                       input logic quad);
    shin = quad ? {s[27:0], d} : {s[30:0], d[0]};
  endfunction

  function automatic logic toggled(input logic [7:0] m);
    toggled = ((m[7:4] ^ m[3:0]) == 4'hF);
  endfunction

  function automatic logic [31:0] next_addr(input logic [31:0] a,
                                            input logic en,
                                            input logic [1:0] sz);
    logic [31:0] mask;
    mask = (32'h0000_0008 << sz) - 32'h0000_0001;
    next_addr = en ? ((a & ~mask) | ((a + 32'h1) & mask)) : a + 32'h1;
  endfunction

  function automatic logic [5:0] pick4(input logic [1:0] s,
                                       input logic [5:0] c0,
                                       input logic [5:0] c1,
                                       input logic [5:0] c2,
                                       input logic [5:0] c3);
    case (s)
      2'h0: pick4 = c0;
      2'h1: pick4 = c1;
      2'h2: pick4 = c2;
      default: pick4 = c3;
    endcase
  endfunction

  // ************************************************************
  // Sequencer state
  // ************************************************************
  sfr_state_e state_reg;
  logic [5:0] cnt_reg;
  logic [31:0] sh_reg, addr_reg, boot_reg;
  logic [7:0] op_reg;
  logic cont_reg, cont_frm_reg, a4_reg, wrap_use_reg, boot_frm_reg;
  logic wrap_en_reg, boot_pend_reg, init_reg, ones_reg;
  logic [1:0] wrap_sz_reg;
  logic [3:0] tot_reg;
  logic [4:0] bcnt_reg;
  wire [31:0] boot_base = {boot_reg[31:BOOT_ADDR_LSB], 4'h0}; // [R21]

  wire in_wide = (state_reg == SFR_CMD) || (state_reg == SFR_WRAP) ||
                 (state_reg == SFR_BPROG);
  wire [31:0] sh_nx = shin(sh_reg, s_pin.sio, in_wide ? qpi_mode : 1'b1);
  wire [5:0] dum_clks = pick4({dummy_cfg_hi, dummy_cfg_lo}, DUMMY_C0,
                              DUMMY_C1, DUMMY_C2, DUMMY_C3); // [R9]
  wire [5:0] dly_clks = pick4(boot_reg[BOOT_DLY_LSB+:2], DLY_C0, DLY_C1,
                              DLY_C2, DLY_C3); // [R20]
  wire [5:0] cmd_last = qpi_mode ? 6'h01 : 6'h07; // [R14]
  wire [7:0] op_nx = sh_nx[7:0];
  wire is_quad_rd = (op_nx == CMD_QIO_EB) || (op_nx == CMD_QIO_EC) ||
                    (op_nx == CMD_QIO_ED) || (op_nx == CMD_QIO_EE); // [R3]
  wire wide_op = (op_nx == CMD_QIO_EC) || (op_nx == CMD_QIO_EE);
  wire [3:0] exit_clks = a4_reg ? EXIT_CLKS_4B : EXIT_CLKS_3B;
  wire force_exit = cs_rise & cont_frm_reg & ones_reg &
                    (tot_reg >= exit_clks); // [R5] [R6]
  wire last = (state_reg == SFR_CMD) ? (cnt_reg == cmd_last) :
              (state_reg == SFR_ADDR) ? (cnt_reg == (a4_reg ? 6'h07 : 6'h05)) :
              (state_reg == SFR_MODE) ? (cnt_reg == 6'h01) :
              (state_reg == SFR_DUMMY) ? (cnt_reg == dum_clks - 6'h01) :
              (state_reg == SFR_BOOT) ? (cnt_reg == dly_clks - 6'h01) :
              (state_reg == SFR_WRAP) ? (cnt_reg == cmd_last) :
              (state_reg == SFR_BPROG) ?
                (cnt_reg == (qpi_mode ? 6'h07 : 6'h1F)) : 1'b0;
  wire rst_cmd = rise & last & (state_reg == SFR_CMD) & (op_nx == CMD_RESET);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SFR_IDLE;
      cnt_reg <= '0;
      sh_reg <= '0;
      op_reg <= '0;
      addr_reg <= '0;
      a4_reg <= 1'b0;
      wrap_use_reg <= 1'b0;
      boot_frm_reg <= 1'b0;
    end else if (s_pin.cs_n) begin
      state_reg <= SFR_IDLE;
      cnt_reg <= '0;
      boot_frm_reg <= 1'b0;
    end else if (cs_fall) begin
      cnt_reg <= '0;
      if (boot_pend_reg) begin
        state_reg <= SFR_BOOT; // [R16]
        boot_frm_reg <= 1'b1;
        wrap_use_reg <= 1'b0;
        addr_reg <= boot_base; // [R21]
      end else if (cont_reg) begin
        state_reg <= SFR_ADDR; // [R4]
      end else begin
        state_reg <= SFR_CMD;
      end
    end else if (rise) begin
      sh_reg <= sh_nx;
      cnt_reg <= last ? 6'h00 : cnt_reg + 6'h01;
      if (last) begin
        case (state_reg)
          SFR_CMD: begin
            op_reg <= op_nx;
            a4_reg <= wide_op | addr4_mode;
            wrap_use_reg <= (op_nx == CMD_QIO_EC) ||
                            ((op_nx == CMD_QIO_EB) && qpi_mode); // [R15]
            if (is_quad_rd) state_reg <= SFR_ADDR; // [R8]
            else if (op_nx == CMD_SET_BURST) state_reg <= SFR_WRAP;
            else if (op_nx == CMD_BOOT_PROG) state_reg <= SFR_BPROG;
            else if (op_nx == CMD_BOOT_READ) state_reg <= SFR_BREAD;
            else state_reg <= SFR_SKIP;
          end
          SFR_ADDR: begin
            addr_reg <= a4_reg ? sh_nx : {8'h00, sh_nx[23:0]};
            state_reg <= SFR_MODE;
          end
          SFR_MODE: state_reg <= SFR_DUMMY;
          SFR_DUMMY: state_reg <= SFR_DATA;
          SFR_BOOT: state_reg <= SFR_DATA; // [R18]
          default: state_reg <= SFR_SKIP;
        endcase
      end
    end else if (fall && state_reg == SFR_DATA && bcnt_reg == '0) begin
      addr_reg <= next_addr(addr_reg, wrap_use_reg & wrap_en_reg,
                            wrap_sz_reg); // [R12]
    end
  end

  // ************************************************************
  // Mode, wrap and boot configuration
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cont_reg <= 1'b0; // [R7]
      cont_frm_reg <= 1'b0;
      wrap_en_reg <= 1'b0; // [R10]
      wrap_sz_reg <= 2'h0;
      ones_reg <= 1'b1;
      tot_reg <= '0;
    end else begin
      if (cs_fall) begin
        cont_frm_reg <= cont_reg & ~boot_pend_reg;
        ones_reg <= 1'b1;
        tot_reg <= '0;
      end else if (rise && !s_pin.cs_n) begin
        if (tot_reg != 4'hF) tot_reg <= tot_reg + 4'h1;
        if (tot_reg < exit_clks && !s_pin.sio[0]) ones_reg <= 1'b0;
      end
      if (rst_cmd) begin
        cont_reg <= 1'b0; // [R7]
        wrap_en_reg <= 1'b0; // [R10]
      end else if (force_exit) begin
        cont_reg <= 1'b0;
      end else if (rise && last && state_reg == SFR_MODE) begin
        cont_reg <= toggled(sh_nx[7:0]); // [R1] [R2]
      end else if (rise && last && state_reg == SFR_WRAP) begin
        wrap_en_reg <= ~sh_nx[WRAP_OFF_BIT]; // [R11] [R13]
        wrap_sz_reg <= sh_nx[1:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_reg <= BOOT_NV_INIT;
      boot_pend_reg <= 1'b0;
      init_reg <= 1'b0;
    end else begin
      init_reg <= 1'b1;
      if (!init_reg || rst_cmd) begin
        boot_pend_reg <= ~boot_reg[BOOT_EN_N_BIT]; // [R16] [R17]
      end else if (cs_rise && boot_frm_reg) begin
        boot_pend_reg <= 1'b0; // [R18]
      end
      if (rise && last && state_reg == SFR_BPROG) begin
        boot_reg <= boot_reg & sh_nx; // [R23]
      end else if (rise && last && state_reg == SFR_CMD &&
                   op_nx == CMD_BOOT_ERASE) begin
        boot_reg <= BOOT_ERASED; // [R23]
      end
    end
  end

  // ************************************************************
  // Array fetch and read buffer
  // ************************************************************
  logic [31:0] fetch_addr_reg;
  logic [1:0] fly_reg;
  logic buf_valid, buf_ready;
  logic [7:0] buf_data;
  wire fetch_on = (state_reg == SFR_DUMMY) || (state_reg == SFR_DATA) ||
                  (state_reg == SFR_BOOT);
  wire data_quad = boot_frm_reg ? quad_enable_bit : 1'b1; // [R22]
  wire byte_ld = fall & (state_reg == SFR_DATA) & (bcnt_reg == '0);
  wire issue = mem_req_valid & mem_req_ready;
  assign mem_req_valid = fetch_on & (fly_reg < FETCH_AHEAD);
  assign mem_req_addr = fetch_addr_reg;
  assign buf_ready = fetch_on ? byte_ld : 1'b1;
  wire pop = buf_valid & buf_ready;

  sfr_fifo2 #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_buf (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(mem_rsp_valid),
    .in_ready(mem_rsp_ready),
    .in_data(mem_rsp_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_addr_reg <= '0;
      fly_reg <= '0;
    end else begin
      fly_reg <= fly_reg + {1'b0, issue} - {1'b0, pop};
      if (cs_fall && boot_pend_reg) fetch_addr_reg <= boot_base; // [R21]
      else if (!fetch_on) fetch_addr_reg <= addr_reg;
      else if (issue) fetch_addr_reg <= next_addr(fetch_addr_reg,
                          wrap_use_reg & wrap_en_reg, wrap_sz_reg);
    end
  end

  // ************************************************************
  // Output shifter on falling sclk
  // ************************************************************
  logic [31:0] out_sh_reg;
  logic [3:0] oe_reg;
  wire out_state = (state_reg == SFR_DATA) || (state_reg == SFR_BREAD);
  wire oq = (state_reg == SFR_BREAD) ? qpi_mode : data_quad;
  wire [4:0] b_last = (state_reg == SFR_BREAD) ? (oq ? 5'h07 : 5'h1F) :
                      (oq ? 5'h01 : 5'h07);
  wire [31:0] ld_val = (state_reg == SFR_BREAD) ? boot_reg :
                       {(buf_valid ? buf_data : 8'hFF), 24'h0};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_sh_reg <= '0;
      bcnt_reg <= '0;
      oe_reg <= '0;
    end else if (s_pin.cs_n || !out_state) begin
      bcnt_reg <= '0;
      oe_reg <= '0;
    end else if (fall) begin
      out_sh_reg <= (bcnt_reg == '0) ? ld_val :
                    (oq ? {out_sh_reg[27:0], 4'h0} : {out_sh_reg[30:0], 1'b0});
      bcnt_reg <= (bcnt_reg == b_last) ? 5'h00 : bcnt_reg + 5'h01;
      oe_reg <= oq ? 4'hF : 4'h2; // [R22]
    end
  end

  assign drv_o.sio_out = oq ? out_sh_reg[31:28] : {2'b00, out_sh_reg[31], 1'b0};
  assign drv_o.sio_oe = oe_reg;
  assign cont_mode_o = cont_reg;
  assign wrap_en_o = wrap_en_reg;
  assign boot_readout_config = boot_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_mode_done;
    rise && state_reg == SFR_MODE && last;
  endsequence
  sequence s_plain_start;
    cs_fall && !s_pin.cs_n && !boot_pend_reg;
  endsequence

  AST_MODE_KEEP: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
    s_mode_done ##0 (toggled(sh_nx[7:0]) && !rst_cmd) |=> cont_reg)
    else $error("toggled mode byte did not keep continuous mode");
  AST_MODE_EXIT: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
    s_mode_done ##0 !toggled(sh_nx[7:0]) |=> !cont_reg)
    else $error("non-toggled mode byte kept continuous mode");
  AST_CONT_SKIP: assert property (@(posedge mclk) disable iff (!rst_n) // [R4]
    s_plain_start ##0 cont_reg |=> state_reg == SFR_ADDR)
    else $error("continuous frame did not start with address");
  AST_NO_CONT_CMD: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
    s_plain_start ##0 !cont_reg |=> state_reg == SFR_CMD)
    else $error("normal frame did not start with command");
  AST_WRAP_OFF: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
    (!init_reg || rst_cmd) |=> !wrap_en_reg)
    else $error("wrap enabled after reset");
  AST_BOOT_GO: assert property (@(posedge mclk) disable iff (!rst_n) // [R16]
    cs_fall && !s_pin.cs_n && boot_pend_reg |=>
      state_reg == SFR_BOOT && addr_reg[3:0] == 4'h0)
    else $error("boot frame did not start at aligned address");
  AST_BOOT_DLY: assert property (@(posedge mclk) disable iff (!rst_n) // [R18]
    rise && state_reg == SFR_BOOT && cnt_reg == dly_clks - 6'h01 &&
      !s_pin.cs_n |=> state_reg == SFR_DATA)
    else $error("boot delay count wrong");
  AST_DUMMY: assert property (@(posedge mclk) disable iff (!rst_n) // [R9]
    rise && state_reg == SFR_DUMMY && cnt_reg < dum_clks - 6'h01 &&
      !s_pin.cs_n |=> state_reg == SFR_DUMMY)
    else $error("dummy phase ended early");
  AST_LINES: assert property (@(posedge mclk) disable iff (!rst_n) // [R22]
    state_reg == SFR_DATA && boot_frm_reg && oe_reg != 4'h0 |->
      oe_reg == (quad_enable_bit ? 4'hF : 4'h2))
    else $error("boot data on wrong lines");
  AST_CS_IDLE: assert property (@(posedge mclk) disable iff (!rst_n) // [R18]
    s_pin.cs_n |=> state_reg == SFR_IDLE && oe_reg == 4'h0)
    else $error("select high did not end the frame");
endmodule
`default_nettype wire

// [sfr_host.sv]
// Purpose: host controller model driving the flash pins
// Assumes: sclk period 16 mclk, idle low between frames
// Notes: released sio lines flip on every deselect
`timescale 1ns/1ps
`default_nettype none
module sfr_host (
  input wire logic mclk,
  output sfr_pkg::sfr_pin_s pin,
  input wire sfr_pkg::sfr_drv_s drv
);
  import sfr_pkg::*;
  // ************************************************************
  // Pin tasks
  // ************************************************************
  initial pin = '{cs_n: 1'b1, sclk: 1'b0, sio: 4'h5};
  // One sclk period; returns what the flash drove before the rise
  task automatic tick(input logic [3:0] v, output logic [3:0] got);
    pin.sio = v;
    repeat (8) @(negedge mclk);
    got = drv.sio_out;
    pin.sclk = 1'b1;
    repeat (8) @(negedge mclk);
    pin.sclk = 1'b0;
  endtask
  task automatic sel();
    pin.cs_n = 1'b0;
    repeat (6) @(negedge mclk);
  endtask
  task automatic desel();
    repeat (4) @(negedge mclk);
    pin.cs_n = 1'b1;
    pin.sio = ~pin.sio;
    repeat (12) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// [sfr_seq_bench.sv]
// Purpose: self-checking bench for the flash read sequencer
// Assumes: array byte at address a reads a[7:0] xor 5A
// Notes: boot starts enabled, 13 delay clocks, start 130h
`timescale 1ns/1ps
`default_nettype none
module sfr_seq_bench;
  import sfr_pkg::*;
  localparam logic [31:0] BOOT_INIT = 32'h0000_0136;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic qpi_mode = 1'b0;
  logic addr4_mode = 1'b0;
  logic quad_enable_bit = 1'b1;
  logic dummy_cfg_lo = 1'b0;
  logic dummy_cfg_hi = 1'b0;
  logic mem_rsp_valid = 1'b0;
  logic [7:0] mem_rsp_data = 8'h00;
  logic mem_req_valid, mem_rsp_ready, cont_mode_o, wrap_en_o, wide;
  logic [31:0] mem_req_addr, boot_readout_config, req_a;
  logic req_hit = 1'b0;
  logic rsp_hit = 1'b0;
  logic [31:0] q[$];
  sfr_pin_s pin;
  sfr_drv_s drv;
  int fail_count = 0;
  int checked = 0;
  // ************************************************************
  // Clock, partner, design and array model
  // ************************************************************
  always #5 mclk = ~mclk;
  sfr_host host (.mclk(mclk), .pin(pin), .drv(drv));
  sfr_seq #(.BOOT_NV_INIT(BOOT_INIT), .BUF_DEPTH(2)) dut (
    .mclk(mclk), .arst_n(arst_n), .pin_i(pin), .drv_o(drv),
    .qpi_mode(qpi_mode), .addr4_mode(addr4_mode),
    .quad_enable_bit(quad_enable_bit), .dummy_cfg_lo(dummy_cfg_lo),
    .dummy_cfg_hi(dummy_cfg_hi), .mem_req_valid(mem_req_valid),
    .mem_req_ready(1'b1), .mem_req_addr(mem_req_addr),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_ready(mem_rsp_ready),
    .mem_rsp_data(mem_rsp_data), .cont_mode_o(cont_mode_o),
    .wrap_en_o(wrap_en_o), .boot_readout_config(boot_readout_config));
  // Handshakes seen here land at the next rising edge
  always @(negedge mclk) begin
    if (rsp_hit) void'(q.pop_front());
    if (req_hit) q.push_back(req_a);
    mem_rsp_valid = q.size() > 0;
    mem_rsp_data = (q.size() > 0) ? (q[0][7:0] ^ 8'h5A) : 8'h00;
    rsp_hit = mem_rsp_valid & mem_rsp_ready;
    req_hit = mem_req_valid;
    req_a = mem_req_addr;
  end
  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic nibs(input logic [31:0] v, input int n);
    logic [3:0] g;
    for (int i = n - 1; i >= 0; i--) host.tick(v[4*i+:4], g);
  endtask
  task automatic send8(input logic [7:0] b);
    logic [3:0] g;
    if (qpi_mode) nibs({24'h0, b}, 2);
    else for (int i = 7; i >= 0; i--) host.tick({3'b101, b[i]}, g);
  endtask
  task automatic rdb(input logic [7:0] e);
    logic [3:0] hi, lo;
    host.tick(4'h3, hi);
    host.tick(4'hC, lo);
    chk("data", {24'h0, e}, {24'h0, hi, lo});
    chk("oe", 32'hF, {28'h0, drv.sio_oe});
  endtask
  task automatic frame(input logic wc, input logic [7:0] op, input logic [31:0] a,
                       input logic [7:0] m, input int nd, input int nb, input logic [31:0] wm);
    logic [31:0] ea;
    host.sel();
    if (wc) wide = addr4_mode | (op inside {CMD_QIO_EC, CMD_QIO_EE});
    if (wc) send8(op);
    nibs(a, wide ? 8 : 6);
    nibs({24'h0, m}, 2);
    nibs(32'h0, nd);
    for (int i = 0; i < nb; i++) begin
      ea = (a & ~wm) | ((a + i) & wm);
      rdb(ea[7:0] ^ 8'h5A);
    end
    host.desel();
  endtask
  task automatic cmd_only(input logic [7:0] op);
    host.sel();
    send8(op);
    host.desel();
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_boot(input logic qe);
    logic [3:0] g;
    logic [7:0] b;
    quad_enable_bit = qe;
    host.sel();
    repeat (13) host.tick(4'h0, g);
    if (qe) rdb(8'h6A);
    for (int i = 0; i < 8 && !qe; i++) begin
      host.tick(4'h0, g);
      b = {b[6:0], g[1]};
    end
    if (!qe) chk("boot1", 32'h6A, {24'h0, b});
    host.desel();
  endtask
  task automatic t_modes();
    logic [7:0] keep [4];
    logic [7:0] quit [4];
    logic [7:0] ops [4];
    keep = '{8'hA5, 8'h5A, 8'hF0, 8'h0F};
    quit = '{8'hFF, 8'h00, 8'hAA, 8'h55};
    ops = '{CMD_QIO_EB, CMD_QIO_EC, CMD_QIO_ED, CMD_QIO_EE};
    frame(1'b1, CMD_QIO_EB, 32'h123, 8'hA5, 4, 2, '1);
    foreach (keep[i]) begin
      frame(1'b0, 8'h00, 32'h200 + i, keep[i], 4, 1, '1);
      chk("cont", 32'h1, cont_mode_o);
    end
    foreach (quit[i]) begin
      frame(1'b0, 8'h00, 32'h300 + i, quit[i], 4, 1, '1);
      chk("cont", 32'h0, cont_mode_o);
      frame(1'b1, ops[i], 32'h400 + i, 8'hA5, 4, 1, '1);
      chk("cont", 32'h1, cont_mode_o);
    end
    frame(1'b0, 8'h00, 32'h10, 8'h00, 4, 1, '1);
    chk("cont", 32'h0, cont_mode_o);
    frame(1'b1, 8'hBB, 32'h10, 8'hA5, 4, 0, '1);
    chk("cont", 32'h0, cont_mode_o);
  endtask
  task automatic t_exit();
    logic [3:0] g;
    frame(1'b1, CMD_QIO_EE, 32'h20, 8'hA5, 4, 1, '1);
    for (int k = 0; k < 3; k++) begin
      qpi_mode = (k == 2);
      if (k > 0) frame(1'b1, CMD_QIO_EB, 32'h30, 8'hA5, 4, 1, '1);
      host.sel();
      repeat (wide ? 10 : 8) host.tick(qpi_mode ? 4'hF : 4'h1, g);
      host.desel();
      chk("cont", 32'h0, cont_mode_o);
    end
  endtask
  task automatic t_wrap();
    dummy_cfg_lo = 1'b1;
    for (int c = 0; c < 4; c++) begin
      cmd_only(CMD_SET_BURST);
      frame(1'b1, CMD_SET_BURST, 32'h0, 8'h0, 0, 0, '1);
      host.sel();
      send8(CMD_SET_BURST);
      send8(c[7:0]);
      host.desel();
      chk("wrap", 32'h1, wrap_en_o);
      frame(1'b1, CMD_QIO_EB, 32'h800 + (8 << c) - 2, 8'h00, 6, 3, (8 << c) - 1);
    end
    dummy_cfg_hi = 1'b1;
    dummy_cfg_lo = 1'b0;
    frame(1'b1, CMD_QIO_EB, 32'h40, 8'h00, 8, 1, 32'h7);
    cmd_only(CMD_RESET);
    chk("cont", 32'h0, cont_mode_o);
    chk("wrap", 32'h0, wrap_en_o);
    qpi_mode = 1'b0;
    t_boot(1'b0);
  endtask
  task automatic t_reg();
    logic [31:0] rv;
    qpi_mode = 1'b1;
    cmd_only(CMD_BOOT_ERASE);
    chk("bootreg", 32'hFFFF_FFFF, boot_readout_config);
    host.sel();
    send8(CMD_BOOT_PROG);
    nibs(32'h1234_567F, 8);
    host.desel();
    host.sel();
    send8(CMD_BOOT_PROG);
    nibs(32'hF0F0_FFFE, 8);
    host.desel();
    chk("bootreg", 32'h1030_567E, boot_readout_config);
    host.sel();
    send8(CMD_BOOT_READ);
    for (int i = 7; i >= 0; i--) host.tick(4'h0, rv[4*i+:4]);
    host.desel();
    chk("bootrd", 32'h1030_567E, rv);
    frame(1'b1, CMD_QIO_EB, 32'h50, 8'hA5, 8, 1, '1);
    host.sel();
    nibs(32'h0, 3);
    arst_n = 1'b0;
    repeat (3) @(negedge mclk);
    chk("cont", 32'h0, cont_mode_o);
    chk("wrap", 32'h0, wrap_en_o);
    arst_n = 1'b1;
    host.desel();
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge mclk);
    arst_n = 1'b1;
    repeat (8) @(negedge mclk);
    chk("cont", 32'h0, cont_mode_o);
    chk("wrap", 32'h0, wrap_en_o);
    chk("bootreg", BOOT_INIT, boot_readout_config);
    t_boot(1'b1);
    t_modes();
    t_exit();
    t_wrap();
    t_reg();
    test_done();
  end
  initial begin
    #800000;
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire
